//--- logic/ltsl_consts.vh
// register map, reset values and timing constants for the latch and trip seal block
// assumes a 125 mhz system clock and a quarter-cycle evaluation tick
`ifndef LTSL_CONSTS_VH
`define LTSL_CONSTS_VH

`define LTSL_CLK_HZ 125000000
`define LTSL_TICKS_PER_SEC 240
`define LTSL_MS_PER_SEC 1000

`define LTSL_ADDR_CONFIG 8'h00
`define LTSL_ADDR_MIN_DUR 8'h04
`define LTSL_ADDR_COMMAND 8'h08
`define LTSL_ADDR_STATUS 8'h0c
`define LTSL_ADDR_NV_COUNT 8'h10

`define LTSL_CFG_COUNT_LSB 0
`define LTSL_CFG_COUNT_MSB 4
`define LTSL_CFG_COUNT_RST 5'h10

`define LTSL_DUR_MS_RST 16'h0096

`define LTSL_CMD_OPEN_BIT 0
`define LTSL_CMD_TARGET_RESET_BIT 1

`define LTSL_STAT_LATCH_LSB 0
`define LTSL_STAT_TRIP_LSB 16
`define LTSL_STAT_TRIP_ANY_BIT 20
`define LTSL_STAT_NV_FAIL_BIT 21
`define LTSL_STAT_RUN_BIT 22

`define LTSL_NV_WRITE_LIMIT 32'h0014e753

`define LTSL_ST_RESTORE 2'h0
`define LTSL_ST_RUN 2'h1

`endif

//--- logic/ltsl_trip_chan.v
// one trip channel: minimum-duration timer plus seal-in with qualified release
// assumes tick_i is a one-cycle pulse per evaluation and inputs are on mclk_i
module ltsl_trip_chan #(
	parameter DUR_W = 16
) (
	input wire mclk_i,
	input wire rst_i,
	input wire tick_i,
	input wire trip_condition_i,
	input wire force_open_i,
	input wire release_i,
	input wire [DUR_W-1:0] dur_ticks_i,
	output wire trip_output_o
);

	reg [DUR_W-1:0] tmr_q;
	reg [DUR_W-1:0] tmr_d;
	reg in_prev_q;
	reg trip_q;
	reg trip_d;
	wire tmr_in;

	assign tmr_in = trip_condition_i | force_open_i;
	assign trip_output_o = trip_q;

	always @* begin
		tmr_d = tmr_q;
		if (tmr_q != {DUR_W{1'b0}}) begin
			tmr_d = tmr_q - {{(DUR_W-1){1'b0}}, 1'b1};
		end else if (tmr_in && !in_prev_q) begin
			// retrigger only when idle, a rise while timing is ignored
			tmr_d = dur_ticks_i;
		end
		// seal holds until timer done, condition low and a release seen
		trip_d = trip_condition_i | (tmr_d != {DUR_W{1'b0}}) | (trip_q & ~release_i);
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			tmr_q <= {DUR_W{1'b0}};
			in_prev_q <= 1'b0;
			trip_q <= 1'b0;
		end else if (tick_i) begin
			tmr_q <= tmr_d;
			in_prev_q <= tmr_in;
			trip_q <= trip_d;
		end
	end

endmodule // ltsl_trip_chan

//--- logic/ltsl_core.v
// latch control switches and four-channel trip seal logic behind an ahb-lite slave
// assumes condition inputs come from equation logic on mclk_i; nv store answers on mclk_i
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`include "ltsl_consts.vh"

module ltsl_core #(
	parameter NLATCH = 16,
	parameter NTRIP = 4,
	parameter DUR_W = 16,
	parameter TICK_CYCLES = `LTSL_CLK_HZ / `LTSL_TICKS_PER_SEC,
	parameter NV_WRITE_LIMIT = `LTSL_NV_WRITE_LIMIT
) (
	input wire mclk_i,
	input wire rst_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	input wire [NLATCH-1:0] latch_set_condition_i,
	input wire [NLATCH-1:0] latch_clear_condition_i,
	input wire [NTRIP-1:0] trip_condition_i,
	input wire [NTRIP-1:0] unlatch_condition_i,
	input wire target_reset_button_i,
	output wire [NLATCH-1:0] latch_bit_o,
	output wire [NTRIP-1:0] trip_output_o,
	output wire trip_any_o,
	output wire eval_tick_o,
	output wire nv_rd_req_o,
	input wire nv_rd_valid_i,
	input wire [NLATCH-1:0] nv_rd_data_i,
	output wire nv_wr_o,
	output wire [NLATCH-1:0] nv_wr_data_o,
	output wire nv_fail_o
);

	// duration register holds milliseconds; rounded up to whole ticks
	function [DUR_W-1:0] ms_to_ticks;
		input [15:0] ms;
		reg [31:0] prod;
		begin
			prod = {16'h0000, ms} * `LTSL_TICKS_PER_SEC + (`LTSL_MS_PER_SEC - 1);
			prod = prod / `LTSL_MS_PER_SEC;
			ms_to_ticks = prod[DUR_W-1:0];
		end
	endfunction

	function [NLATCH-1:0] count_mask;
		input [4:0] cnt;
		integer k;
		begin
			count_mask = {NLATCH{1'b0}};
			for (k = 0; k < NLATCH; k = k + 1) begin
				if (k < cnt)
					count_mask[k] = 1'b1;
			end
		end
	endfunction

	// bus state
	reg wr_pend_q;
	reg rd_pend_q;
	reg [7:0] addr_q;
	reg [31:0] hrdata_q;
	reg hreadyout_q;
	reg [31:0] rd_mux;
	wire ahb_go;

	// configuration
	reg [4:0] latch_count_enable_q;
	reg [15:0] min_dur_ms_q;
	reg [DUR_W-1:0] min_trip_duration_q;

	// commands and button, held until the next tick
	reg open_pend_q;
	reg tres_pend_q;
	reg btn_s1_q;
	reg btn_s2_q;
	reg btn_s3_q;
	wire btn_press;

	// evaluation tick
	reg [31:0] tick_cnt_q;
	reg tick_q;

	// latches and store
	reg [1:0] state_q;
	reg [NLATCH-1:0] latch_bit_q;
	reg [NLATCH-1:0] latch_d;
	reg [NLATCH-1:0] latch_out_q;
	reg nv_rd_req_q;
	reg nv_wr_q;
	reg [NLATCH-1:0] nv_wr_data_q;
	reg [31:0] nv_count_q;
	reg nv_fail_q;
	wire [NLATCH-1:0] active_mask;

	// trips
	wire [NTRIP-1:0] trip_raw;
	reg [NTRIP-1:0] trip_out_q;
	reg trip_any_q;
	wire release_common;

	integer i;
	genvar g;

	assign ahb_go = hsel_i & htrans_i[1] & hready_i;
	assign btn_press = btn_s2_q & ~btn_s3_q;
	assign active_mask = count_mask(latch_count_enable_q);
	assign release_common = tres_pend_q;

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hreadyout_q;
	assign hresp_o = 1'b0;
	assign latch_bit_o = latch_out_q;
	assign trip_output_o = trip_out_q;
	assign trip_any_o = trip_any_q;
	assign eval_tick_o = tick_q;
	assign nv_rd_req_o = nv_rd_req_q;
	assign nv_wr_o = nv_wr_q;
	assign nv_wr_data_o = nv_wr_data_q;
	assign nv_fail_o = nv_fail_q;

	always @* begin
		rd_mux = 32'h00000000;
		case (addr_q)
		`LTSL_ADDR_CONFIG: begin
			rd_mux[`LTSL_CFG_COUNT_MSB:`LTSL_CFG_COUNT_LSB] = latch_count_enable_q;
		end
		`LTSL_ADDR_MIN_DUR: begin
			rd_mux[15:0] = min_dur_ms_q;
		end
		`LTSL_ADDR_STATUS: begin
			rd_mux[`LTSL_STAT_LATCH_LSB +: NLATCH] = latch_out_q;
			rd_mux[`LTSL_STAT_TRIP_LSB +: NTRIP] = trip_out_q;
			rd_mux[`LTSL_STAT_TRIP_ANY_BIT] = trip_any_q;
			rd_mux[`LTSL_STAT_NV_FAIL_BIT] = nv_fail_q;
			rd_mux[`LTSL_STAT_RUN_BIT] = (state_q == `LTSL_ST_RUN);
		end
		`LTSL_ADDR_NV_COUNT: begin
			rd_mux = nv_count_q;
		end
		default: begin
			rd_mux = 32'h00000000;
		end
		endcase
	end

	// reads take one wait state so a write just before is already visible
	always @(posedge mclk_i) begin
		if (rst_i) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
		end else begin
			wr_pend_q <= ahb_go & hwrite_i;
			rd_pend_q <= ahb_go & ~hwrite_i;
			if (ahb_go)
				addr_q <= {haddr_i[7:2], 2'b00};
			if (ahb_go && !hwrite_i) begin
				hreadyout_q <= 1'b0;
			end else if (rd_pend_q) begin
				hrdata_q <= rd_mux;
				hreadyout_q <= 1'b1;
			end
		end
	end

	// settings writes touch only config; latch state is never reloaded here
	always @(posedge mclk_i) begin
		if (rst_i) begin
			latch_count_enable_q <= `LTSL_CFG_COUNT_RST;
			min_dur_ms_q <= `LTSL_DUR_MS_RST;
			min_trip_duration_q <= ms_to_ticks(`LTSL_DUR_MS_RST);
		end else if (wr_pend_q) begin
			if (addr_q == `LTSL_ADDR_CONFIG) begin
				if (hwdata_i[`LTSL_CFG_COUNT_MSB:`LTSL_CFG_COUNT_LSB] > NLATCH)
					latch_count_enable_q <= NLATCH[4:0];
				else
					latch_count_enable_q <= hwdata_i[`LTSL_CFG_COUNT_MSB:`LTSL_CFG_COUNT_LSB];
			end
			if (addr_q == `LTSL_ADDR_MIN_DUR) begin
				min_dur_ms_q <= hwdata_i[15:0];
				min_trip_duration_q <= ms_to_ticks(hwdata_i[15:0]);
			end
		end
	end

	// command pulses wait for the tick; a new command wins over the tick clear
	always @(posedge mclk_i) begin
		if (rst_i) begin
			btn_s1_q <= 1'b0;
			btn_s2_q <= 1'b0;
			btn_s3_q <= 1'b0;
			open_pend_q <= 1'b0;
			tres_pend_q <= 1'b0;
		end else begin
			btn_s1_q <= target_reset_button_i;
			btn_s2_q <= btn_s1_q;
			btn_s3_q <= btn_s2_q;
			if (wr_pend_q && addr_q == `LTSL_ADDR_COMMAND && hwdata_i[`LTSL_CMD_OPEN_BIT])
				open_pend_q <= 1'b1;
			else if (tick_q)
				open_pend_q <= 1'b0;
			if (btn_press || (wr_pend_q && addr_q == `LTSL_ADDR_COMMAND && hwdata_i[`LTSL_CMD_TARGET_RESET_BIT]))
				tres_pend_q <= 1'b1;
			else if (tick_q)
				tres_pend_q <= 1'b0;
		end
	end

	// quarter-cycle tick, held off until latch restore is done
	always @(posedge mclk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (state_q != `LTSL_ST_RUN) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	always @* begin
		latch_d = latch_bit_q;
		for (i = 0; i < NLATCH; i = i + 1) begin
			if (active_mask[i]) begin
				if (latch_clear_condition_i[i])
					latch_d[i] = 1'b0;
				else if (latch_set_condition_i[i])
					latch_d[i] = 1'b1;
			end
		end
	end

	// inactive latches keep their stored value but read as zero
	always @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= `LTSL_ST_RESTORE;
			latch_bit_q <= {NLATCH{1'b0}};
			latch_out_q <= {NLATCH{1'b0}};
			nv_rd_req_q <= 1'b0;
			nv_wr_q <= 1'b0;
			nv_wr_data_q <= {NLATCH{1'b0}};
			nv_count_q <= 32'h00000000;
			nv_fail_q <= 1'b0;
		end else begin
			nv_wr_q <= 1'b0;
			latch_out_q <= latch_bit_q & active_mask;
			case (state_q)
			`LTSL_ST_RESTORE: begin
				nv_rd_req_q <= ~nv_rd_valid_i;
				if (nv_rd_valid_i) begin
					latch_bit_q <= nv_rd_data_i;
					state_q <= `LTSL_ST_RUN;
				end
			end
			`LTSL_ST_RUN: begin
				nv_rd_req_q <= 1'b0;
				if (tick_q) begin
					latch_bit_q <= latch_d;
					if (latch_d != latch_bit_q) begin
						nv_wr_q <= 1'b1;
						nv_wr_data_q <= latch_d;
						if (nv_count_q != 32'hffffffff)
							nv_count_q <= nv_count_q + 32'h00000001;
					end
				end
			end
			default: begin
				state_q <= `LTSL_ST_RESTORE;
			end
			endcase
			// endurance is a wear estimate: sticky until reset
			if (nv_count_q >= NV_WRITE_LIMIT)
				nv_fail_q <= 1'b1;
		end
	end

	// trips read latch and variable results from the previous tick
	generate
		for (g = 0; g < NTRIP; g = g + 1) begin : chan
			ltsl_trip_chan #(
				.DUR_W(DUR_W)
			) u_chan (
				.mclk_i(mclk_i),
				.rst_i(rst_i),
				.tick_i(tick_q),
				.trip_condition_i(trip_condition_i[g]),
				.force_open_i((g == 0) ? open_pend_q : 1'b0),
				.release_i(unlatch_condition_i[g] | release_common),
				.dur_ticks_i(min_trip_duration_q),
				.trip_output_o(trip_raw[g])
			);
		end
	endgenerate

	always @(posedge mclk_i) begin
		if (rst_i) begin
			trip_out_q <= {NTRIP{1'b0}};
			trip_any_q <= 1'b0;
		end else begin
			trip_out_q <= trip_raw;
			trip_any_q <= |trip_raw;
		end
	end

endmodule // ltsl_core

//--- sim/ltsl_core_sva.sv
// assertions on the latch and trip seal core ports
// assumes one clock domain and a synchronous active-high reset
module ltsl_core_chk #(parameter NLATCH = 16, parameter NTRIP = 4) (
	input logic mclk_i,
	input logic rst_i,
	input logic eval_tick_o,
	input logic [NLATCH-1:0] latch_set_condition_i,
	input logic [NLATCH-1:0] latch_clear_condition_i,
	input logic [NLATCH-1:0] latch_bit_o,
	input logic [NTRIP-1:0] trip_output_o,
	input logic trip_any_o,
	input logic nv_rd_req_o,
	input logic nv_rd_valid_i,
	input logic [NLATCH-1:0] nv_rd_data_i,
	input logic nv_wr_o,
	input logic [NLATCH-1:0] nv_wr_data_o,
	input logic nv_fail_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// last vector known to sit in the store
	logic [NLATCH-1:0] last_q;
	always_ff @(posedge mclk_i) begin
		if (nv_rd_req_o && nv_rd_valid_i)
			last_q <= nv_rd_data_i;
		else if (nv_wr_o)
			last_q <= nv_wr_data_o;
	end
	sequence s_restore;
		nv_rd_req_o && nv_rd_valid_i;
	endsequence
	sequence s_both;
		eval_tick_o && latch_set_condition_i[NLATCH-1] && latch_clear_condition_i[NLATCH-1];
	endsequence
	property p_set; eval_tick_o && latch_set_condition_i[0] && !latch_clear_condition_i[0] |-> ##[1:3] latch_bit_o[0]; endproperty
	property p_clr; eval_tick_o && latch_clear_condition_i[0] |-> ##[1:3] !latch_bit_o[0]; endproperty
	property p_both; s_both |-> ##[1:3] !latch_bit_o[NLATCH-1]; endproperty
	property p_restore; s_restore |-> ##[1:3] latch_bit_o == last_q; endproperty
	property p_any; trip_any_o == |trip_output_o; endproperty
	property p_first; eval_tick_o |-> !nv_rd_req_o; endproperty
	property p_wr; nv_wr_o |-> nv_wr_data_o != last_q; endproperty
	property p_fail; nv_fail_o |=> nv_fail_o; endproperty
	a_set: assert property (p_set) else $error("latch set missed");
	a_clr: assert property (p_clr) else $error("latch clear missed");
	a_both: assert property (p_both) else $error("clear did not win");
	a_restore: assert property (p_restore) else $error("restore mismatch");
	a_any: assert property (p_any) else $error("aggregate trip wrong");
	a_first: assert property (p_first) else $error("tick before restore");
	a_wr: assert property (p_wr) else $error("store write without change");
	a_fail: assert property (p_fail) else $error("store failure not sticky");
endmodule // ltsl_core_chk

bind ltsl_core ltsl_core_chk #(.NLATCH(NLATCH), .NTRIP(NTRIP)) ltsl_core_chk_i (.mclk_i, .rst_i, .eval_tick_o,
	.latch_set_condition_i, .latch_clear_condition_i, .latch_bit_o, .trip_output_o, .trip_any_o, .nv_rd_req_o,
	.nv_rd_valid_i, .nv_rd_data_i, .nv_wr_o, .nv_wr_data_o, .nv_fail_o);

//--- sim/ltsl_nv_model.sv
// nonvolatile store model for the latch vector
// assumes pulses on mclk_i; slow_i stretches the restore answer
module ltsl_nv_model #(parameter [15:0] INIT = 16'ha5c3) (
	input logic mclk_i,
	input logic slow_i,
	input logic rd_req_i,
	input logic wr_i,
	input logic [15:0] wr_data_i,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem = INIT;
	int n = 0;
	initial begin
		rd_valid_o = 1'b0;
		rd_data_o = ~INIT;
	end
	always @(posedge mclk_i) begin
		rd_valid_o <= 1'b0;
		// off the answer the data is scrambled, never the stored word
		rd_data_o <= ~mem;
		if (wr_i)
			mem <= wr_data_i;
		if (rd_req_i && !rd_valid_o) begin
			n <= n + 1;
			if (n >= (slow_i ? 5 : 1)) begin
				rd_valid_o <= 1'b1;
				rd_data_o <= mem;
				n <= 0;
			end
		end
	end
endmodule // ltsl_nv_model

//--- sim/ltsl_core_tb.sv
// self-checking bench for the latch and trip seal core
// assumes shortened tick and endurance parameters and single-word ahb-lite transfers
module ltsl_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, rst_i = 1, hsel_i = 1, hwrite_i = 0, target_reset_button_i = 0, slow = 0;
	logic [1:0] htrans_i = '0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, rd;
	logic [15:0] latch_set_condition_i = '0, latch_clear_condition_i = '0, latch_bit_o, nv_rd_data_i, nv_wr_data_o;
	logic [3:0] trip_condition_i = '0, unlatch_condition_i = '0, trip_output_o, trp = '0, pc = '0;
	logic hreadyout_o, hresp_o, trip_any_o, eval_tick_o, nv_rd_req_o, nv_rd_valid_i, nv_wr_o, nv_fail_o;
	logic po = 0, pr = 0;
	logic [15:0] lat = 16'ha5c3, mk, nl;
	logic [7:0] ad[4] = '{8'h00, 8'h04, 8'h08, 8'h14};
	logic [31:0] ev[4] = '{32'h10, 32'h96, 32'h0, 32'h0};
	int fail_count = 0, n_compared = 0, seed = 49, cnt = 16, dur = 36, writes = 0, tmr[4] = '{0, 0, 0, 0};
	always #4 mclk_i = ~mclk_i;
	ltsl_core #(.TICK_CYCLES(8), .NV_WRITE_LIMIT(3)) ltsl_core_i (.mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
		.latch_set_condition_i, .latch_clear_condition_i, .trip_condition_i, .unlatch_condition_i,
		.target_reset_button_i, .latch_bit_o, .trip_output_o, .trip_any_o, .eval_tick_o, .nv_rd_req_o,
		.nv_rd_valid_i, .nv_rd_data_i, .nv_wr_o, .nv_wr_data_o, .nv_fail_o);
	ltsl_nv_model ltsl_nv_model_i (.mclk_i, .slow_i(slow), .rd_req_i(nv_rd_req_o), .wr_i(nv_wr_o),
		.wr_data_i(nv_wr_data_o), .rd_valid_o(nv_rd_valid_i), .rd_data_o(nv_rd_data_i));
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait on the tick pulse or on hready
	task automatic wait_hi(input bit tick);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while ((tick ? eval_tick_o : hreadyout_o) !== 1'b1 && n < 60);
		if ((tick ? eval_tick_o : hreadyout_o) !== 1'b1) begin
			chk("wait", 1, 0);
			results();
		end
	endtask
	task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		wait_hi(0);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_hi(0);
		rd = hrdata_o;
		chk("hresp_o", 32'h0, {31'h0, hresp_o});
	endtask
	// conditions change just after a tick so they stand still across the next one
	task automatic step(input logic [15:0] s, c, input logic [3:0] tc, ul, input bit rel, opn, b, ct);
		logic [15:0] m;
		@(posedge mclk_i);
		latch_set_condition_i <= s;
		latch_clear_condition_i <= c;
		trip_condition_i <= tc;
		unlatch_condition_i <= ul;
		target_reset_button_i <= b;
		// commands wait in the model until the next tick, as in the design
		po = po | opn;
		pr = pr | rel;
		wait_hi(1);
		repeat (3) @(posedge mclk_i);
		#1;
		m = 16'((32'h1 << cnt) - 1);
		chk("latch_bit_o", {16'h0, lat & m}, {16'h0, latch_bit_o});
		if (ct) begin
			chk("trip_output_o", {28'h0, trp}, {28'h0, trip_output_o});
			chk("trip_any_o", {31'h0, |trp}, {31'h0, trip_any_o});
		end
	endtask
	// reference model: one evaluation per tick, so ticks during bus reads are counted too
	always @(posedge mclk_i) begin
		if (!rst_i && eval_tick_o === 1'b1) begin
			mk = 16'((32'h1 << cnt) - 1);
			nl = (lat & ~mk) | ((lat | latch_set_condition_i) & ~latch_clear_condition_i & mk);
			writes += int'(nl != lat);
			lat = nl;
			for (int i = 0; i < 4; i++) begin
				// a rise while the timer still counts is ignored
				if (tmr[i] > 0)
					tmr[i]--;
				else if ((trip_condition_i[i] || (i == 0 && po)) && !pc[i])
					tmr[i] = dur;
				trp[i] = trip_condition_i[i] || tmr[i] > 0 || (trp[i] && !(unlatch_condition_i[i] || pr));
				pc[i] = trip_condition_i[i] || (i == 0 && po);
			end
			po = 1'b0;
			pr = 1'b0;
		end
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		step('0, '0, '0, '0, 0, 0, 0, 1);
		ahb(1, 8'h14, 32'hffffffff);
		for (int i = 0; i < 4; i++) begin
			ahb(0, ad[i], 0);
			chk("register", ev[i], rd);
		end
		ahb(1, 8'h04, 32'hd);
		dur = 4;
		for (int k = 0; k < 40; k++)
			step(16'($random(seed)), 16'($random(seed)), 4'($random(seed)), 4'($random(seed)), 0, 0, 0, 1);
		ahb(0, 8'h0c, 0);
		chk("status", {9'h0, 1'b1, writes >= 3, |trp, trp, lat}, rd);
		ahb(0, 8'h10, 0);
		chk("nv_count", writes, rd);
		chk("nv_fail_o", {31'h0, writes >= 3}, {31'h0, nv_fail_o});
		repeat (5) step('0, '0, '0, '1, 0, 0, 0, 1);
		ahb(1, 8'h08, 32'h1);
		step('0, '0, '0, '0, 0, 1, 0, 1);
		repeat (5) step('0, '0, '0, '0, 0, 0, 0, 1);
		ahb(1, 8'h08, 32'h2);
		step('0, '0, '0, '0, 1, 0, 0, 0);
		step('0, '0, '0, '0, 0, 0, 0, 1);
		repeat (6) step('0, '0, 4'h8, 4'h8, 0, 0, 0, 1);
		step('0, '0, '0, '0, 0, 0, 0, 1);
		step('0, '0, '0, '0, 1, 0, 1, 0);
		step('0, '0, '0, '0, 0, 0, 0, 1);
		ahb(1, 8'h00, 32'h1);
		cnt = 1;
		step('1, '0, '0, '0, 0, 0, 0, 1);
		ahb(1, 8'h00, 32'h14);
		cnt = 16;
		ahb(0, 8'h00, 0);
		chk("config", 32'h10, rd);
		step('0, '0, '0, '0, 0, 0, 0, 1);
		slow <= 1'b1;
		rst_i <= 1'b1;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		trp = '0;
		pc = '0;
		po = 1'b0;
		pr = 1'b0;
		tmr = '{0, 0, 0, 0};
		dur = 36;
		step('0, '0, '0, '0, 0, 0, 0, 1);
		for (int k = 0; k < 10; k++)
			step(16'($random(seed)), 16'($random(seed)), 4'($random(seed)), 4'($random(seed)), 0, 0, 0, 1);
		results();
	end
endmodule // ltsl_core_tb
